// file: verilog/acc_conversion_control.sv
// How it works
// - Enable bit powers converter; clearing turns off
// - Clearing enable aborts running conversion immediately
// - Single mode: each start write, one conversion
// - Free running: start launches first, rest automatic
// - First conversion after enable 25 cycles, else 13
// - Start reads one until conversion completes
// - Writing zero to start is ignored
// - Auto trigger: start on selected trigger rising edge
// - Trigger source from second control register field
// - Done flag set together with result update
// - Interrupt needs flag, enable and global enable
// - Interrupt vector execution clears done flag
// - Writing one clears done flag; zero keeps
// - Three-bit field selects converter clock divider
// - Input select change waits for conversion end
// - Selecting free running never causes a trigger
module acc_conversion_control
	import acc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,
	input  wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ACC_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [6:0]            trigger_sources,
	input  wire logic                  global_irq_enable,
	input  wire logic                  irq_vector_ack,
	input  wire logic [9:0]            core_result,
	output logic                       converter_power,
	output logic                       converter_clk_tick,
	output logic                       conversion_active,
	output logic                       conversion_init,
	output logic                       conversion_done,
	output logic                       irq_request,
	output logic [4:0]                 applied_pos,
	output logic [3:0]                 applied_neg,
	output logic                       applied_diff,
	output logic [1:0]                 applied_gain,
	output logic                       applied_valid
);

	typedef struct packed {
		logic [4:0] pos;
		logic [3:0] neg;
		logic       diff;
		logic [1:0] gain;
		logic       valid;
	} acc_route_type;

	typedef struct packed {
		acc_state_type st;
		logic          en;
		logic          start;
		logic          ate;
		logic          flag;
		logic          ie;
		logic [2:0]    div;
		logic [2:0]    tsrc;
		logic [5:0]    sel;
		logic [5:0]    sel_app;
		acc_route_type route;
		logic          init_need;
		logic          first;
		logic [4:0]    cnt;
		logic          done;
		logic          trig_prev;
		logic [9:0]    result;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [1:0]    rresp;
		logic [31:0]   rdata;
	} acc_regs_type;

	acc_regs_type st_q;
	acc_regs_type st_d;
	logic         tick;

	////////////////////////////////////////////////////////////////////////
	// Input routing decode for the analog multiplexer and gain stage
	function automatic acc_route_type acc_decode(input logic [5:0] m);
		acc_route_type r;
		logic [3:0]    base;
		r = '0;
		base = 4'h0;
		r.valid = 1'b1;
		if (m[4:3] == 2'b00) begin
			r.pos = {1'b0, m[5], m[2:0]};
		end else if (m[4:3] == 2'b01) begin
			base = {m[5], 1'b0, m[2], 1'b0};
			r.pos = {1'b0, base[3:1], m[0]};
			r.neg = base;
			r.diff = 1'b1;
			r.gain = m[1] ? ACC_GAIN_200X : ACC_GAIN_10X;
		end else if (m[2:1] == 2'b11 && m[3]) begin
			r.pos = m[0] ? ACC_POS_GROUND : ACC_POS_BANDGAP;
			r.valid = ~m[5];
		end else begin
			r.pos = {1'b0, m[5], m[2:0]};
			r.neg = {m[5], 1'b0, m[3], ~m[3]};
			r.diff = 1'b1;
			r.gain = ACC_GAIN_1X;
		end
		acc_decode = r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Converter clock divider
	acc_clock_divider u_div (
		.mclk         (mclk),
		.sys_rst      (sys_rst),
		.run          (st_q.en),
		.ratio_select (st_q.div),
		.tick         (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus handshakes: one write and one read outstanding at most
	logic       wr_go;
	logic       rd_go;
	logic       wr_hit;
	logic [9:0] wr_idx;
	logic [9:0] rd_idx;
	logic [7:0] wd;

	assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~st_q.bvalid;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = ~st_q.rvalid;
	assign wr_go  = s_axi_awready;
	assign rd_go  = s_axi_arvalid & ~st_q.rvalid;
	assign wr_idx = s_axi_awaddr[11:2];
	assign rd_idx = s_axi_araddr[11:2];
	assign wd     = s_axi_wdata[7:0];
	assign wr_hit = wr_go & s_axi_wstrb[0];

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	logic       trig_sel;
	logic       trig_edge;
	logic       start_req;
	logic       go;
	logic       done_evt;
	logic       idx_ok;
	logic [4:0] len;

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		start_req = 1'b0;
		done_evt = 1'b0;
		go = 1'b0;
		idx_ok = 1'b0;
		len = st_q.first ? ACC_CONV_CYCLES_FIRST : ACC_CONV_CYCLES_NORMAL;

		// Write channel
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_d.bvalid = 1'b1;
			st_d.bresp = ACC_RESP_OKAY;
			case (wr_idx)
				ACC_IDX_CTRL_A, ACC_IDX_CTRL_B, ACC_IDX_INPUT_SEL,
				ACC_IDX_RESULT_LO, ACC_IDX_RESULT_HI: idx_ok = 1'b1;
				default: idx_ok = 1'b0;
			endcase
			if (!idx_ok) begin
				st_d.bresp = ACC_RESP_SLVERR;
			end
		end
		if (wr_hit) begin
			case (wr_idx)
				ACC_IDX_CTRL_A: begin
					st_d.en = wd[ACC_A_ENABLE];
					st_d.ate = wd[ACC_A_AUTO_TRIG];
					st_d.ie = wd[ACC_A_IRQ_ENABLE];
					st_d.div = wd[ACC_A_DIV_LSB +: 3];
					start_req = wd[ACC_A_START];
					if (wd[ACC_A_DONE_FLAG]) begin
						st_d.flag = 1'b0;
					end
				end
				ACC_IDX_CTRL_B: begin
					st_d.sel[5] = wd[ACC_B_SEL_TOP];
					st_d.tsrc = wd[ACC_B_TRIG_LSB +: 3];
				end
				ACC_IDX_INPUT_SEL: begin
					st_d.sel[4:0] = wd[ACC_SEL_LOW_LSB +: 5];
				end
				default: begin
				end
			endcase
		end
		if (irq_vector_ack) begin
			st_d.flag = 1'b0;
		end

		// Read channel
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (rd_go) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = ACC_RESP_OKAY;
			st_d.rdata = 32'h0000_0000;
			case (rd_idx)
				ACC_IDX_CTRL_A: begin
					st_d.rdata[7:0] = {st_q.en, st_q.start, st_q.ate, st_q.flag, st_q.ie, st_q.div};
				end
				ACC_IDX_CTRL_B: begin
					st_d.rdata[7:0] = {4'h0, st_q.sel[5], st_q.tsrc};
				end
				ACC_IDX_INPUT_SEL: begin
					st_d.rdata[7:0] = {3'h0, st_q.sel[4:0]};
				end
				ACC_IDX_RESULT_LO: begin
					st_d.rdata[7:0] = st_q.result[7:0];
				end
				ACC_IDX_RESULT_HI: begin
					st_d.rdata[7:0] = {6'h00, st_q.result[9:8]};
				end
				default: begin
					st_d.rresp = ACC_RESP_SLVERR;
				end
			endcase
		end

		// Conversion timing in converter clock cycles
		if (st_q.st == ACC_CONV && tick) begin
			if (st_q.cnt == len - 5'h01) begin
				done_evt = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt + 5'h01;
			end
		end
		if (done_evt) begin
			st_d.result = core_result;
			st_d.flag = 1'b1;
			st_d.done = 1'b1;
			st_d.start = 1'b0;
			st_d.st = ACC_IDLE;
		end

		// Trigger selection; free running is handled off the done event instead
		trig_sel = (st_q.tsrc != 3'h0) ? trigger_sources[st_q.tsrc - 3'h1] : 1'b0;
		st_d.trig_prev = trig_sel;
		trig_edge = st_q.ate & trig_sel & ~st_q.trig_prev;

		// Enable rising arms the long first conversion
		if (!st_q.en && st_d.en) begin
			st_d.init_need = 1'b1;
			st_d.st = ACC_IDLE;
		end

		// Start only when not already converting
		if (st_d.en && st_d.st != ACC_CONV) begin
			go = start_req | trig_edge | (st_q.ate & st_q.tsrc == 3'h0 & done_evt);
		end
		if (go) begin
			st_d.st = ACC_CONV;
			st_d.cnt = 5'h00;
			st_d.start = 1'b1;
			st_d.first = st_d.init_need;
			st_d.init_need = 1'b0;
		end

		// Disable wins over any start, trigger or restart, aborting a running conversion
		if (!st_d.en) begin
			st_d.st = ACC_OFF;
			st_d.start = 1'b0;
			st_d.cnt = 5'h00;
		end

		// Routing follows the select between conversions, so a free running restart takes the new code
		if (st_d.st != ACC_CONV || done_evt) begin
			st_d.sel_app = st_d.sel;
		end
		st_d.route = acc_decode(st_d.sel_app);
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.st <= ACC_OFF;
			st_q.sel <= ACC_INPUT_SEL_RESET;
			st_q.sel_app <= ACC_INPUT_SEL_RESET;
			st_q.en <= ACC_CTRL_A_RESET[ACC_A_ENABLE];
			st_q.div <= ACC_CTRL_A_RESET[ACC_A_DIV_LSB +: 3];
			st_q.tsrc <= ACC_CTRL_B_RESET[ACC_B_TRIG_LSB +: 3];
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_bvalid       = st_q.bvalid;
	assign s_axi_bresp        = st_q.bresp;
	assign s_axi_rvalid       = st_q.rvalid;
	assign s_axi_rresp        = st_q.rresp;
	assign s_axi_rdata        = st_q.rdata;
	assign converter_power    = st_q.en;
	assign converter_clk_tick = tick;
	assign conversion_active  = (st_q.st == ACC_CONV);
	assign conversion_init    = (st_q.st == ACC_CONV) & st_q.first;
	assign conversion_done    = st_q.done;
	assign irq_request        = st_q.flag & st_q.ie & global_irq_enable;
	assign applied_pos        = st_q.route.pos;
	assign applied_neg        = st_q.route.neg;
	assign applied_diff       = st_q.route.diff;
	assign applied_gain       = st_q.route.gain;
	assign applied_valid      = st_q.route.valid;

endmodule

// file: verilog/acc_pkg.sv
package acc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map: printed offsets are indices, byte address is four times
	localparam int          ACC_ADDR_W         = 12;
	localparam logic [9:0]  ACC_IDX_RESULT_LO  = 10'h078;
	localparam logic [9:0]  ACC_IDX_RESULT_HI  = 10'h079;
	localparam logic [9:0]  ACC_IDX_CTRL_A     = 10'h07a;
	localparam logic [9:0]  ACC_IDX_CTRL_B     = 10'h07b;
	localparam logic [9:0]  ACC_IDX_INPUT_SEL  = 10'h07c;

	////////////////////////////////////////////////////////////////////////
	// Field positions in converter_control_status_a
	localparam int          ACC_A_ENABLE       = 7;
	localparam int          ACC_A_START        = 6;
	localparam int          ACC_A_AUTO_TRIG    = 5;
	localparam int          ACC_A_DONE_FLAG    = 4;
	localparam int          ACC_A_IRQ_ENABLE   = 3;
	localparam int          ACC_A_DIV_LSB      = 0;

	// Field positions in converter_control_status_b and the input select register
	localparam int          ACC_B_SEL_TOP      = 3;
	localparam int          ACC_B_TRIG_LSB     = 0;
	localparam int          ACC_SEL_LOW_LSB    = 0;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0]  ACC_CTRL_A_RESET   = 8'h00;
	localparam logic [7:0]  ACC_CTRL_B_RESET   = 8'h00;
	localparam logic [5:0]  ACC_INPUT_SEL_RESET = 6'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing, in converter clock cycles
	localparam logic [4:0]  ACC_CONV_CYCLES_NORMAL = 5'h0d;
	localparam logic [4:0]  ACC_CONV_CYCLES_FIRST  = 5'h19;

	// Bus answers
	localparam logic [1:0]  ACC_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  ACC_RESP_SLVERR    = 2'h2;

	// Gain codes and special input codes on the analog side
	localparam logic [1:0]  ACC_GAIN_1X        = 2'h0;
	localparam logic [1:0]  ACC_GAIN_10X       = 2'h1;
	localparam logic [1:0]  ACC_GAIN_200X      = 2'h2;
	localparam logic [4:0]  ACC_POS_BANDGAP    = 5'h10;
	localparam logic [4:0]  ACC_POS_GROUND     = 5'h11;

	typedef enum logic [1:0] {
		ACC_OFF  = 2'h0,
		ACC_IDLE = 2'h1,
		ACC_CONV = 2'h3
	} acc_state_type;

	function automatic logic [7:0] acc_div_ratio(input logic [2:0] s);
		case (s)
			3'h0:    acc_div_ratio = 8'h02;
			3'h1:    acc_div_ratio = 8'h02;
			3'h2:    acc_div_ratio = 8'h04;
			3'h3:    acc_div_ratio = 8'h08;
			3'h4:    acc_div_ratio = 8'h10;
			3'h5:    acc_div_ratio = 8'h20;
			3'h6:    acc_div_ratio = 8'h40;
			default: acc_div_ratio = 8'h80;
		endcase
	endfunction

endpackage

// file: verilog/acc_clock_divider.sv
module acc_clock_divider
	import acc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       run,
	input  wire logic [2:0] ratio_select,
	output logic            tick
);

	typedef struct packed {
		logic [6:0] cnt;
		logic       tick;
	} acc_div_regs_type;

	acc_div_regs_type st_q;
	acc_div_regs_type st_d;
	logic [7:0]       limit;

	assign limit = acc_div_ratio(ratio_select) - 8'h01;

	////////////////////////////////////////////////////////////////////////
	// Comparing with >= keeps the counter sane when the ratio drops mid-count
	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (!run) begin
			st_d.cnt = 7'h00;
		end else if ({1'b0, st_q.cnt} >= limit) begin
			st_d.cnt = 7'h00;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 7'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign tick = st_q.tick;

endmodule

// file: testbench/acc_conversion_control_chk.sv
module acc_conversion_control_chk
	import acc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       global_irq_enable,
	input wire logic       converter_power,
	input wire logic       converter_clk_tick,
	input wire logic       conversion_active,
	input wire logic       conversion_init,
	input wire logic       conversion_done,
	input wire logic       irq_request,
	input wire logic [4:0] applied_pos,
	input wire logic [3:0] applied_neg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////
	chk_power_idle: assert property (!converter_power |-> !conversion_active && !conversion_init)
		else $error("conversion running while powered off");
	chk_tick_off: assert property (!converter_power && !$past(converter_power) |-> !converter_clk_tick)
		else $error("converter clock ticks while off");
	chk_tick_gap: assert property (converter_clk_tick |=> !converter_clk_tick)
		else $error("converter clock ticks on adjacent cycles");
	chk_init_active: assert property (conversion_init |-> conversion_active)
		else $error("init marked outside a conversion");
	chk_done_ends: assert property (conversion_done |-> $past(conversion_active))
		else $error("done without a running conversion");
	chk_done_pulse: assert property (conversion_done |=> !conversion_done)
		else $error("done pulse longer than one cycle");
	// Excludes the end edge, where a free running restart may reload the selection
	chk_sel_hold: assert property (conversion_active && $past(conversion_active) && !conversion_done
		|-> $stable(applied_pos) && $stable(applied_neg))
		else $error("input selection moved during conversion");
	chk_irq_gate: assert property (irq_request |-> global_irq_enable)
		else $error("interrupt requested while globally masked");

	cover property (conversion_init ##1 conversion_active);
	cover property (conversion_done && conversion_active);
	cover property (irq_request);
endmodule

bind acc_conversion_control acc_conversion_control_chk chk_u (
	.mclk, .sys_rst, .global_irq_enable, .converter_power, .converter_clk_tick, .conversion_active,
	.conversion_init, .conversion_done, .irq_request, .applied_pos, .applied_neg
);

// file: testbench/acc_core_model.sv
module acc_core_model
	import acc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       conversion_active,
	input  wire logic [4:0] applied_pos,
	input  wire logic       applied_diff,
	input  wire logic [1:0] applied_gain,
	output logic      [9:0] core_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip_q = 1'b0;
	// Idle output toggles so a sample taken outside a conversion is caught
	always_ff @(posedge mclk) flip_q <= ~flip_q;
	assign core_result = conversion_active ? {applied_gain, applied_diff, 2'h0, applied_pos} : {10{flip_q}};
endmodule

// file: testbench/adc_conversion_control_tb_top.sv
module adc_conversion_control_tb_top
	import acc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [9:0]  IA = ACC_IDX_CTRL_A, IB = ACC_IDX_CTRL_B, IS = ACC_IDX_INPUT_SEL;
	localparam logic [9:0]  IL = ACC_IDX_RESULT_LO, IH = ACC_IDX_RESULT_HI;
	// Code, then valid, diff, gain, negative and positive input
	localparam logic [18:0] dec [9] = '{{6'h1e, 13'h1010}, {6'h1f, 13'h1011}, {6'h23, 13'h100b},
		{6'h19, 13'h1841}, {6'h31, 13'h1929}, {6'h3b, 13'h194b}, {6'h0f, 13'h1c43},
		{6'h28, 13'h1b08}, {6'h12, 13'h1822}};
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [6:0]  trigger_sources = 7'h00;
	logic        global_irq_enable = 1'b0, irq_vector_ack = 1'b0;
	logic [9:0]  core_result;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, applied_gain;
	logic [31:0] s_axi_rdata;
	logic        converter_power, converter_clk_tick, conversion_active, conversion_init;
	logic        conversion_done, irq_request, applied_diff, applied_valid;
	logic [4:0]  applied_pos;
	logic [3:0]  applied_neg;
	wire  [12:0] dec_seen = {applied_valid, applied_diff, applied_gain, applied_neg, applied_pos};
	int          miscompares = 0, comparisons = 0, cyc = 0, dones = 0;

	acc_conversion_control dut_u (
		.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_sources, .global_irq_enable,
		.irq_vector_ack, .core_result, .converter_power, .converter_clk_tick,
		.conversion_active, .conversion_init, .conversion_done, .irq_request,
		.applied_pos, .applied_neg, .applied_diff, .applied_gain, .applied_valid
	);
	acc_core_model core_u (.mclk, .conversion_active, .applied_pos, .applied_diff, .applied_gain, .core_result);

	////////////////////////////////////////////////////////////////
	always #2.5 mclk = ~mclk;

	task automatic give_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	// Write address and data go out together; bready stays up until bvalid
	task automatic wr(logic [9:0] i, logic [7:0] d, logic [1:0] r = ACC_RESP_OKAY);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge mclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", r, s_axi_bresp);
		@(posedge mclk);
	endtask

	task automatic rd(logic [9:0] i, logic [7:0] e, logic [1:0] r = ACC_RESP_OKAY);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge mclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", {24'h0, e}, s_axi_rdata);
		chk("rresp", r, s_axi_rresp);
		@(posedge mclk);
	endtask

	task automatic wait_done(output int k);
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (conversion_done !== 1'b1);
	endtask

	// Tick phase against the start is unknown, so allow one tick of slack
	function automatic bit in_win(int k, int n, int r);
		return k + 1 >= (n - 1) * r && k + 1 <= n * r + 1;
	endfunction

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (conversion_done === 1'b1)
			dones <= dones + 1;
		if (cyc == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		int k;
		int d;
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		rd(IA, 8'h00);
		rd(IB, 8'h00);
		rd(IS, 8'h00);
		rd(10'h07d, 8'h00, ACC_RESP_SLVERR);
		wr(10'h07d, 8'hff, ACC_RESP_SLVERR);
		wr(IL, 8'h55);
		rd(IL, 8'h00);
		$display("register map test done");
		for (int j = 0; j < 9; j++) begin
			wr(IB, {4'h0, dec[j][18], 3'h0});
			wr(IS, {3'h0, dec[j][17:13]});
			chk("decode", dec[j][12:0], dec_seen);
		end
		wr(IB, 8'h08);
		wr(IS, 8'h1e);
		chk("reserved", 0, applied_valid);
		$display("input decode test done");
		wr(IS, 8'h0d);
		wr(IA, 8'hc0);
		chk("init", 1, conversion_init);
		chk("power", 1, converter_power);
		wait_done(k);
		chk("first length", 1, in_win(k, 25, 2));
		rd(IA, 8'h90);
		rd(IL, 8'h8b);
		rd(IH, 8'h01);
		$display("first conversion test done");
		wr(IA, 8'hcb);
		chk("init", 0, conversion_init);
		wait_done(k);
		chk("length", 1, in_win(k, 13, 8));
		rd(IA, 8'h9b);
		chk("irq masked", 0, irq_request);
		global_irq_enable <= 1'b1;
		@(posedge mclk);
		chk("irq", 1, irq_request);
		wr(IA, 8'h8b);
		rd(IA, 8'h9b);
		wr(IA, 8'h9b);
		rd(IA, 8'h8b);
		chk("irq cleared", 0, irq_request);
		$display("flag and irq test done");
		wr(IA, 8'hcb);
		wr(IB, 8'h00);
		chk("held pos", 5'h0b, applied_pos);
		rd(IA, 8'hcb);
		wait_done(k);
		@(posedge mclk);
		chk("new pos", 5'h03, applied_pos);
		chk("irq", 1, irq_request);
		irq_vector_ack <= 1'b1;
		@(posedge mclk);
		irq_vector_ack <= 1'b0;
		@(posedge mclk);
		rd(IA, 8'h8b);
		wr(IA, 8'hc3);
		wr(IA, 8'h03);
		chk("aborted", 0, conversion_active);
		chk("power off", 0, converter_power);
		d = dones;
		repeat (300) @(posedge mclk);
		chk("no done", d, dones);
		rd(IA, 8'h03);
		$display("freeze and abort test done");
		wr(IB, 8'h02);
		wr(IA, 8'ha3);
		trigger_sources <= 7'h01;
		repeat (20) @(posedge mclk);
		chk("other source", 0, conversion_active);
		trigger_sources <= 7'h03;
		repeat (3) @(posedge mclk);
		chk("triggered", 1, conversion_active);
		wait_done(k);
		rd(IA, 8'hb3);
		wr(IB, 8'h00);
		repeat (20) @(posedge mclk);
		chk("free select", 0, conversion_active);
		wr(IA, 8'he3);
		wait_done(k);
		chk("length", 1, in_win(k, 13, 8));
		wait_done(k);
		chk("next length", 1, in_win(k, 13, 8));
		wr(IA, 8'h00);
		$display("trigger test done");
		give_verdict();
	end
endmodule
